/* scope_consts.svh */
`ifndef SCOPE_CONSTS_SVH
`define SCOPE_CONSTS_SVH

`define SAMPLE_WIDTH     8
`define TRACE_DEPTH      256
`define ADDR_WIDTH       8
`define HALF_DEPTH       128
`define FIFO_DEPTH       32
`define FIFO_AW          5
`define DELAY_WIDTH      16
`define CONV_TIME_NS     1000
`define CLK_PERIOD_NS    5
`define CONV_CYCLES      ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CNT_WIDTH   8
`define SRC_CHAN_A       2'h0
`define SRC_CHAN_B       2'h1
`define SRC_EXT          2'h2
`define SRC_MAINS        2'h3

`endif

/* scope_pkg.sv */
package scope_pkg;
	typedef logic [7:0] sample_type;
	typedef logic [7:0] addr_type;

	typedef enum logic [2:0] {
		ACQ_IDLE    = 3'b000,
		ACQ_START   = 3'b001,
		ACQ_CONVERT = 3'b010,
		ACQ_SHIFT   = 3'b011,
		ACQ_FULL    = 3'b100,
		ACQ_COPY    = 3'b101
	} acq_state_type;

	typedef enum logic [1:0] {
		CP_IDLE  = 2'b00,
		CP_COPY  = 2'b01,
		CP_DRAIN = 2'b10
	} copy_state_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} ram_word_type;

	typedef struct packed {
		logic [7:0] x;
		logic [7:0] y;
	} dac_pair_type;
endpackage

/* sample_fifo.sv */
`timescale 1ns/1ps
module sample_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32,
	parameter int AW    = 5
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_rst_b,
	input  wire logic [WIDTH-1:0] i_wr_data,
	input  wire logic             i_wr_valid,
	output logic                  o_wr_ready,
	output logic      [WIDTH-1:0] o_rd_data,
	output logic                  o_rd_valid,
	input  wire logic             i_rd_ready
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr_reg;
	logic [AW:0]      rd_ptr_reg;
	logic             full;
	logic             empty;

	assign empty = (wr_ptr_reg == rd_ptr_reg);
	assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
		(wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
	assign o_wr_ready = !full;
	assign o_rd_valid = !empty;
	assign o_rd_data = mem[rd_ptr_reg[AW-1:0]];

	always_ff @(posedge i_core_clk) begin
		if (i_wr_valid && !full) begin
			mem[wr_ptr_reg[AW-1:0]] <= i_wr_data;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_ptr_reg <= '0;
		end else if (i_wr_valid && !full) begin
			wr_ptr_reg <= wr_ptr_reg + 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rd_ptr_reg <= '0;
		end else if (i_rd_ready && !empty) begin
			rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end
endmodule

/* acquisition_sequencer.sv */
`timescale 1ns/1ps
`include "scope_consts.svh"
// Behaviour
// [RQ1] Converter starts only on sequencer pulse
// [RQ2] Trigger source picks A, B, external, mains
// [RQ3] Delay counter fires pulse after preset delay
// [RQ4] One shift clock per finished conversion
// [RQ5] Shift loads new word, moves others
// [RQ6] Shift register holds 256 words
// [RQ7] Stop after trigger and over 256 shifts
// [RQ8] Full register copied to accumulator by handshake
// [RQ9] After copy, register ready, acquisition restarts
// [RQ10] Accumulator copyable to any of three traces
// [RQ11] Trace holds 256 bytes, 128 per channel
// [RQ12] Each location holds one 8-bit level
// [RQ13] Display counter scans 0 to 255
// [RQ14] Read value drives vertical converter
// [RQ15] Decoded panel settings drive front-end controls
// [RQ16] Display handshake keeps trace flicker free
// [RQ17] Dual mode splits trace halves per channel
// [RQ18] Copies write all 256 in order
module acquisition_sequencer
	import scope_pkg::*;
(
	input  wire logic                    i_core_clk,
	input  wire logic                    i_rst_b,
	input  wire logic                    i_trig_chan_a,
	input  wire logic                    i_trig_chan_b,
	input  wire logic                    i_trig_ext,
	input  wire logic                    i_trig_mains,
	input  wire logic [1:0]              i_trig_select,
	input  wire logic [`DELAY_WIDTH-1:0] i_trig_delay,
	input  wire logic                    i_arm,
	input  wire logic [7:0]              i_adc_data,
	input  wire logic                    i_adc_done,
	output logic                         o_adc_start,
	input  wire logic [7:0]              i_panel_settings,
	output logic      [7:0]              o_front_end_ctrl,
	input  wire logic                    i_dual_channel,
	input  wire logic                    i_store_req,
	input  wire logic [1:0]              i_store_sel,
	output logic                         o_store_done,
	input  wire logic [1:0]              i_display_sel,
	input  wire logic                    i_display_step,
	output logic                         o_display_frame,
	output logic      [7:0]              o_x_dac,
	output logic      [7:0]              o_y_dac,
	output logic                         o_acq_full,
	output logic                         o_accumulation_ram_updated,
	output logic                         o_triggered
);
	// Sample shift register and RAMs
	sample_type       shift_reg [`TRACE_DEPTH];
	sample_type       accumulation_ram_ram [`TRACE_DEPTH];
	sample_type       saved_trace_ram [3][`TRACE_DEPTH];

	acq_state_type    acq_state_reg;
	logic             trig_src;
	logic             trig_src_d_reg;
	logic             trig_delay_run_reg;
	logic [`DELAY_WIDTH-1:0] trig_delay_cnt_reg;
	logic             trig_pulse;
	logic             trig_seen_reg;
	logic [8:0]       shift_cnt_reg;
	logic             shift_clk;
	logic             adc_start_reg;
	logic [`ADDR_WIDTH-1:0] copy_addr_reg;
	logic             fifo_wr_valid;
	logic             fifo_wr_ready;
	ram_word_type     fifo_wr_data;
	ram_word_type     fifo_rd_data;
	logic             fifo_rd_valid;
	logic             fifo_rd_ready;
	logic             accumulation_ram_cnt_done;
	logic [8:0]       accumulation_ram_wr_cnt_reg;
	logic             display_busy;
	copy_state_type   store_state_reg;
	logic [`ADDR_WIDTH-1:0] store_addr_reg;
	logic [1:0]       store_sel_reg;
	logic [`ADDR_WIDTH-1:0] disp_addr_reg;
	logic [`ADDR_WIDTH-1:0] disp_ram_addr;
	sample_type       disp_word;
	logic             frame_wrap;

	function automatic logic trig_pick(input logic [1:0] sel,
		input logic a, input logic b, input logic e, input logic m);
		logic r;
		r = a;
		unique case (sel)
			`SRC_CHAN_A: r = a;
			`SRC_CHAN_B: r = b;
			`SRC_EXT:    r = e;
			`SRC_MAINS:  r = m;
		endcase
		return r;
	endfunction

	assign trig_src = trig_pick(i_trig_select, i_trig_chan_a, // [RQ2]
		i_trig_chan_b, i_trig_ext, i_trig_mains);

	// Settings latched each cycle toward the analogue front end
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_front_end_ctrl <= 8'h00;
		end else begin
			o_front_end_ctrl <= i_panel_settings; // [RQ15]
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			trig_src_d_reg <= 1'b0;
		end else begin
			trig_src_d_reg <= trig_src;
		end
	end

	// Delay counter armed by trigger rising edge while acquiring
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			trig_delay_run_reg <= 1'b0;
			trig_delay_cnt_reg <= '0;
		end else if (acq_state_reg == ACQ_IDLE) begin
			trig_delay_run_reg <= 1'b0;
		end else if (!trig_delay_run_reg && !trig_seen_reg &&
			trig_src && !trig_src_d_reg) begin
			trig_delay_run_reg <= 1'b1;
			trig_delay_cnt_reg <= i_trig_delay; // [RQ3]
		end else if (trig_delay_run_reg) begin
			if (trig_delay_cnt_reg == '0) begin
				trig_delay_run_reg <= 1'b0;
			end else begin
				trig_delay_cnt_reg <= trig_delay_cnt_reg - 1'b1;
			end
		end
	end

	assign trig_pulse = trig_delay_run_reg && (trig_delay_cnt_reg == '0);

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			trig_seen_reg <= 1'b0;
		end else if (acq_state_reg == ACQ_IDLE ||
			(acq_state_reg == ACQ_COPY && accumulation_ram_cnt_done)) begin
			// Each restarted acquisition waits for a fresh trigger
			trig_seen_reg <= 1'b0; // [RQ9]
		end else if (trig_pulse) begin
			trig_seen_reg <= 1'b1;
		end
	end
	assign o_triggered = trig_seen_reg;

	// Acquisition state machine
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			acq_state_reg <= ACQ_IDLE;
		end else begin
			unique case (acq_state_reg)
				ACQ_IDLE: if (i_arm) begin
					acq_state_reg <= ACQ_START;
				end
				ACQ_START: acq_state_reg <= ACQ_CONVERT;
				ACQ_CONVERT: if (i_adc_done) begin
					acq_state_reg <= ACQ_SHIFT;
				end
				ACQ_SHIFT: begin
					if ((trig_seen_reg || trig_pulse) &&
						shift_cnt_reg >= 9'(`TRACE_DEPTH)) begin
						acq_state_reg <= ACQ_FULL; // [RQ7]
					end else begin
						acq_state_reg <= ACQ_START;
					end
				end
				ACQ_FULL: if (!display_busy) begin
					acq_state_reg <= ACQ_COPY; // [RQ8]
				end
				ACQ_COPY: if (accumulation_ram_cnt_done) begin
					acq_state_reg <= ACQ_START; // [RQ9]
				end
				default: acq_state_reg <= ACQ_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			adc_start_reg <= 1'b0;
		end else begin
			adc_start_reg <= (acq_state_reg == ACQ_IDLE && i_arm) ||
				(acq_state_reg == ACQ_SHIFT &&
				!((trig_seen_reg || trig_pulse) &&
				shift_cnt_reg >= 9'(`TRACE_DEPTH))) ||
				(acq_state_reg == ACQ_COPY && accumulation_ram_cnt_done);
		end
	end
	assign o_adc_start = adc_start_reg; // [RQ1]

	assign shift_clk = (acq_state_reg == ACQ_SHIFT); // [RQ4]

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			shift_cnt_reg <= '0;
		end else if (acq_state_reg == ACQ_IDLE ||
			(acq_state_reg == ACQ_COPY && accumulation_ram_cnt_done)) begin
			shift_cnt_reg <= '0;
		end else if (shift_clk && shift_cnt_reg != 9'h1ff) begin
			shift_cnt_reg <= shift_cnt_reg + 1'b1;
		end
	end

	// Shift register chain
	always_ff @(posedge i_core_clk) begin
		if (shift_clk) begin
			shift_reg[0] <= i_adc_data; // [RQ5]
		end
	end

	generate
		for (genvar i = 1; i < `TRACE_DEPTH; i++) begin : g_shift
			always_ff @(posedge i_core_clk) begin
				if (shift_clk) begin
					shift_reg[i] <= shift_reg[i-1]; // [RQ6]
				end
			end
		end
	endgenerate

	assign o_acq_full = (acq_state_reg == ACQ_FULL);

	// Copy source side: oldest sample lands at address 0
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			copy_addr_reg <= '0;
		end else if (acq_state_reg != ACQ_COPY) begin
			copy_addr_reg <= '0;
		end else if (fifo_wr_valid && fifo_wr_ready) begin
			copy_addr_reg <= copy_addr_reg + 1'b1; // [RQ18]
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			accumulation_ram_wr_cnt_reg <= '0;
		end else if (acq_state_reg != ACQ_COPY) begin
			accumulation_ram_wr_cnt_reg <= '0;
		end else if (fifo_wr_valid && fifo_wr_ready) begin
			accumulation_ram_wr_cnt_reg <= accumulation_ram_wr_cnt_reg + 1'b1;
		end
	end

	assign fifo_wr_valid = (acq_state_reg == ACQ_COPY) &&
		(accumulation_ram_wr_cnt_reg < 9'(`TRACE_DEPTH));
	assign fifo_wr_data.addr = copy_addr_reg;
	assign fifo_wr_data.data = shift_reg[8'hff - copy_addr_reg];

	sample_fifo #(
		.WIDTH ($bits(ram_word_type)),
		.DEPTH (`FIFO_DEPTH),
		.AW    (`FIFO_AW)
	) u_copy_fifo (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.i_wr_data  (fifo_wr_data),
		.i_wr_valid (fifo_wr_valid),
		.o_wr_ready (fifo_wr_ready),
		.o_rd_data  (fifo_rd_data),
		.o_rd_valid (fifo_rd_valid),
		.i_rd_ready (fifo_rd_ready)
	);

	// Accumulator writes only at scan end, never under a store copy
	assign fifo_rd_ready = !display_busy && (store_state_reg == CP_IDLE);
	assign accumulation_ram_cnt_done = (accumulation_ram_wr_cnt_reg == 9'(`TRACE_DEPTH)) &&
		!fifo_rd_valid;

	always_ff @(posedge i_core_clk) begin
		if (fifo_rd_valid && fifo_rd_ready) begin
			accumulation_ram_ram[fifo_rd_data.addr] <= fifo_rd_data.data; // [RQ12]
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_accumulation_ram_updated <= 1'b0;
		end else begin
			o_accumulation_ram_updated <= (acq_state_reg == ACQ_COPY) && accumulation_ram_cnt_done;
		end
	end

	// Accumulator to saved trace copy
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			store_state_reg <= CP_IDLE;
			store_addr_reg  <= '0;
			store_sel_reg   <= 2'h0;
		end else begin
			unique case (store_state_reg)
				CP_IDLE: if (i_store_req && i_store_sel != 2'h3 &&
					acq_state_reg != ACQ_COPY) begin
					store_state_reg <= CP_COPY; // [RQ10]
					store_sel_reg   <= i_store_sel;
					store_addr_reg  <= '0;
				end
				CP_COPY: begin
					store_addr_reg <= store_addr_reg + 1'b1;
					if (store_addr_reg == 8'hff) begin
						store_state_reg <= CP_DRAIN; // [RQ18]
					end
				end
				CP_DRAIN: store_state_reg <= CP_IDLE;
				default: store_state_reg <= CP_IDLE;
			endcase
		end
	end

	generate
		for (genvar t = 0; t < 3; t++) begin : g_trace
			always_ff @(posedge i_core_clk) begin
				if (store_state_reg == CP_COPY && store_sel_reg == 2'(t)) begin
					saved_trace_ram[t][store_addr_reg] <= // [RQ11]
						accumulation_ram_ram[store_addr_reg];
				end
			end
		end
	endgenerate

	assign o_store_done = (store_state_reg == CP_DRAIN);

	// Display scan
	assign display_busy = !(disp_addr_reg == 8'hff); // [RQ16]
	assign frame_wrap = i_display_step && (disp_addr_reg == 8'hff);

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			disp_addr_reg <= 8'h00;
		end else if (i_display_step) begin
			disp_addr_reg <= disp_addr_reg + 1'b1; // [RQ13]
		end
	end

	// Dual mode: even points from A half, odd points from B half
	assign disp_ram_addr = i_dual_channel ?
		{disp_addr_reg[0], disp_addr_reg[7:1]} : disp_addr_reg; // [RQ17]

	always_comb begin
		disp_word = accumulation_ram_ram[disp_ram_addr];
		unique case (i_display_sel)
			2'h0: disp_word = accumulation_ram_ram[disp_ram_addr];
			2'h1: disp_word = saved_trace_ram[0][disp_ram_addr];
			2'h2: disp_word = saved_trace_ram[1][disp_ram_addr];
			2'h3: disp_word = saved_trace_ram[2][disp_ram_addr];
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_x_dac <= 8'h00;
			o_y_dac <= 8'h00;
			o_display_frame <= 1'b0;
		end else begin
			o_x_dac <= disp_addr_reg; // [RQ13]
			o_y_dac <= disp_word; // [RQ14]
			o_display_frame <= frame_wrap;
		end
	end
endmodule

/* acq_seq_chk.sv */
`timescale 1ns/1ps
module acq_seq_chk (
	input wire logic       i_core_clk,
	input wire logic       i_rst_b,
	input wire logic [7:0] i_panel_settings,
	input wire logic       i_dual_channel,
	input wire logic       i_store_req,
	input wire logic       o_adc_start,
	input wire logic [7:0] o_front_end_ctrl,
	input wire logic       o_store_done,
	input wire logic       o_display_frame,
	input wire logic [7:0] o_x_dac,
	input wire logic       o_acq_full,
	input wire logic       o_accumulation_ram_updated,
	input wire logic       o_triggered
);
	logic [1:0] up_reg;

	// Counts the first three edges since reset release, then holds at 3
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			up_reg <= 2'h0;
		else if (up_reg != 2'h3)
			up_reg <= up_reg + 2'h1;
	end

	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);

	chk_start_pulse: assert property (
		o_adc_start |=> !o_adc_start) else $error("start too long");
	chk_no_start_full: assert property (
		o_acq_full |-> !o_adc_start) else $error("start while full");
	chk_full_trig: assert property (
		o_acq_full |-> o_triggered) else $error("full untriggered");
	chk_panel_copy: assert property (
		up_reg == 2'h3 |-> o_front_end_ctrl == $past(i_panel_settings))
		else $error("front end copy wrong");
	chk_store_time: assert property (
		$rose(o_store_done) |-> $past(i_store_req, 257))
		else $error("store copy length wrong");
	chk_store_pulse: assert property (
		o_store_done |=> !o_store_done [*2]) else $error("store pulse");
	chk_x_step: assert property (
		!i_dual_channel && $changed(o_x_dac) |->
		o_x_dac == $past(o_x_dac) + 8'h1) else $error("x not stepping");
	chk_frame_wrap: assert property (
		o_display_frame |-> o_x_dac == 8'hff)
		else $error("frame not at wrap");
	chk_accumulation_ram_pulse: assert property (
		o_accumulation_ram_updated |=> !o_accumulation_ram_updated) else $error("accumulation_ram pulse");
	chk_accumulation_ram_scan: assert property (
		$rose(o_accumulation_ram_updated) |-> o_x_dac == 8'hff)
		else $error("accumulation_ram copy off scan end");
endmodule

bind acquisition_sequencer acq_seq_chk acq_seq_chk_i (
	.i_core_clk,
	.i_rst_b,
	.i_panel_settings,
	.i_dual_channel,
	.i_store_req,
	.o_adc_start,
	.o_front_end_ctrl,
	.o_store_done,
	.o_display_frame,
	.o_x_dac,
	.o_acq_full,
	.o_accumulation_ram_updated,
	.o_triggered
);

/* adc_model.sv */
`timescale 1ns/1ps
module adc_model (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_start,
	output logic             o_done,
	output logic      [7:0]  o_data,
	output logic      [15:0] o_count
);
	logic       busy_reg;
	logic [5:0] wait_reg;

	// One word per start; data garbled while converting
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			busy_reg <= 1'b0;
			wait_reg <= 6'h0;
			o_done <= 1'b0;
			o_data <= 8'h00;
			o_count <= 16'h0;
		end else begin
			o_done <= 1'b0;
			if (i_start) begin
				busy_reg <= 1'b1;
				wait_reg <= (o_count[4:0] == 5'h0) ? 6'h28 : {3'h0, o_count[2:0]};
				o_data <= ~o_data;
			end else if (busy_reg && wait_reg != 6'h0) begin
				wait_reg <= wait_reg - 6'h1;
			end else if (busy_reg) begin
				busy_reg <= 1'b0;
				o_done <= 1'b1;
				o_data <= o_count[7:0] ^ o_count[15:8];
				o_count <= o_count + 16'h1;
			end
		end
	end
endmodule

/* acquisition_sequencer_bench.sv */
`timescale 1ns/1ps
module acquisition_sequencer_bench;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [3:0]  trg = 4'h0;
	logic [1:0]  tsel = 2'h0;
	logic [15:0] tdly = 16'h0;
	logic        arm = 1'b0;
	logic [7:0]  panel = 8'h00;
	logic        sreq = 1'b0;
	logic [1:0]  ssel = 2'h0;
	logic [1:0]  dsel = 2'h0;
	logic        dstep = 1'b0;
	logic        dual = 1'b0;
	logic        adc_start, adc_done, sdone, frame, full, accumulation_ram, trig;
	logic [7:0]  adc_data, fec, x, y;
	logic [15:0] cnt;
	logic [31:0] seed = 32'h7c90;
	logic [16:0] q[$];
	logic [16:0] nt;
	logic [7:0]  xe = 8'h00;
	logic [7:0]  last = 8'h00;
	int          n_mismatch = 0;
	int          cmp_count = 0;
	int          n_frame = 0;
	int          n_done = 0;
	int          wraps = 0;
	int          t;
	int          nn;

	acquisition_sequencer acquisition_sequencer_i (
		.i_core_clk(clk),
		.i_rst_b(rst_b),
		.i_trig_chan_a(trg[0]),
		.i_trig_chan_b(trg[1]),
		.i_trig_ext(trg[2]),
		.i_trig_mains(trg[3]),
		.i_trig_select(tsel),
		.i_trig_delay(tdly),
		.i_arm(arm),
		.i_adc_data(adc_data),
		.i_adc_done(adc_done),
		.o_adc_start(adc_start),
		.i_panel_settings(panel),
		.o_front_end_ctrl(fec),
		.i_dual_channel(dual),
		.i_store_req(sreq),
		.i_store_sel(ssel),
		.o_store_done(sdone),
		.i_display_sel(dsel),
		.i_display_step(dstep),
		.o_display_frame(frame),
		.o_x_dac(x),
		.o_y_dac(y),
		.o_acq_full(full),
		.o_accumulation_ram_updated(accumulation_ram),
		.o_triggered(trig)
	);

	adc_model adc_model_i (
		.i_core_clk(clk),
		.i_rst_b(rst_b),
		.i_start(adc_start),
		.o_done(adc_done),
		.o_data(adc_data),
		.o_count(cnt)
	);

	always #2.5 clk = ~clk;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [7:0] smp(input int n);
		return 8'(n) ^ 8'(n >> 8);
	endfunction

	function automatic logic sig(input int k);
		case (k)
			0: return full;
			1: return accumulation_ram;
			2: return sdone;
			default: return trig;
		endcase
	endfunction

	task automatic check(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic wait_hi(input int k, input int lim);
		t = 0;
		while (sig(k) !== 1'b1 && t < lim) begin
			cyc(1);
			t++;
		end
		check(16'(sig(k) === 1'b1), 16'h1, "wait");
	endtask

	// Steps the display and notes the point expected
	task automatic scan(input int n, input logic chk, input int base);
		logic [7:0] a;
		for (int i = 0; i < n; i++) begin
			if (xe == 8'hff)
				wraps++;
			xe = xe + 8'h1;
			// Dual: point k of A at k, of B at 128 + k, alternating
			a = dual ? {xe[0], xe[7:1]} : xe;
			q.push_back({chk, xe, smp(base + int'(a))});
			dstep = 1'b1;
			panel = 8'(rnd());
			cyc(1);
			dstep = 1'b0;
			cyc(5);
		end
	endtask

	always begin
		@(negedge clk);
		if (rst_b && x !== last) begin
			last = x;
			cyc(2);
			if (q.size() == 0) begin
				check(16'h1, 16'h0, "spare point");
			end else begin
				nt = q.pop_front();
				check({8'h0, x}, {8'h0, nt[15:8]}, "x");
				if (nt[16])
					check({8'h0, y}, {8'h0, nt[7:0]}, "y");
			end
		end
	end

	always @(negedge clk) begin
		if (frame === 1'b1)
			n_frame++;
		if (sdone === 1'b1)
			n_done++;
	end

	initial begin
		cyc(60000);
		n_mismatch++;
		$display("Error %0t: run hung", $time);
		end_of_test();
	end

	initial begin
		cyc(3);
		check({2'h0, full, accumulation_ram, trig, sdone, frame, adc_start, x}, 16'h0,
			"reset");
		rst_b = 1'b1;
		arm = 1'b1;
		cyc(1);
		arm = 1'b0;
		for (int r = 0; r < 4; r++) begin
			tsel = 2'(r);
			tdly = 16'h8 + 16'(rnd() & 32'h3f);
			trg[(r + 1) % 4] = 1'b1;
			cyc(20);
			check(16'(trig), 16'h0, "other source");
			trg = 4'h0;
			cyc(1);
			trg[r] = 1'b1;
			wait_hi(3, 200);
			check(16'(t >= tdly && t <= tdly + 6), 16'h1, "delay");
			trg = 4'h0;
			wait_hi(0, 8000);
			nn = int'(cnt) - 256;
			if (r == 0)
				scan(255, 1'b0, 0);
			wait_hi(1, 800);
			dsel = 2'h0;
			scan(256, 1'b1, nn);
			ssel = 2'(r);
			sreq = 1'b1;
			cyc(1);
			sreq = 1'b0;
			if (r < 3) begin
				wait_hi(2, 400);
				check(16'(t), 16'h100, "store time");
				dsel = 2'(r + 1);
				scan(256, 1'b1, nn);
				dsel = 2'h0;
			end else begin
				cyc(300);
				dual = 1'b1;
				scan(256, 1'b1, nn);
				dual = 1'b0;
			end
		end
		cyc(10);
		check(16'(n_done), 16'h3, "store count");
		check(16'(n_frame), 16'(wraps), "frames");
		end_of_test();
	end
endmodule
